// ===== include/gpd_defs.svh
`ifndef GPD_DEFS_SVH
`define GPD_DEFS_SVH

// Register word indices; byte address is four times the index
`define GPD_ADDR_W        6
`define GPD_DIR_IDX       6'h00
`define GPD_DIR_CLR_IDX   6'h01
`define GPD_DIR_SET_IDX   6'h02
`define GPD_DIR_INV_IDX   6'h03
`define GPD_LVL_IDX       6'h04
`define GPD_LVL_CLR_IDX   6'h05
`define GPD_LVL_SET_IDX   6'h06
`define GPD_LVL_INV_IDX   6'h07
`define GPD_LAT_IDX       6'h08
`define GPD_LAT_CLR_IDX   6'h09
`define GPD_LAT_SET_IDX   6'h0a
`define GPD_LAT_INV_IDX   6'h0b

`define GPD_PINS          16
`define GPD_DIR_RESET     16'hffff
`define GPD_LAT_RESET     16'h0000
`define GPD_UNDEF_READ    32'h00000000

`endif

// ===== include/gpd_pkg.sv
package gpd_pkg;

  typedef enum logic [1:0]
  {
    GPD_OP_LOAD,
    GPD_OP_CLR,
    GPD_OP_SET,
    GPD_OP_INV
  } gpd_op_t;

  typedef logic [15:0] gpd_word_t;

endpackage

// ===== rtl/gpd_modify_reg.sv
`timescale 1ns/10ps
`include "gpd_defs.svh"

module gpd_modify_reg
  import gpd_pkg::*;
#(
  parameter gpd_word_t RESET_VALUE = `GPD_LAT_RESET
)
(
  // Clock and reset
  input  wire logic      mclk,
  input  wire logic      rst,
  // Update request
  input  wire logic      wrEn,
  input  wire gpd_op_t   op,
  input  wire gpd_word_t wrData,
  // Stored value
  output gpd_word_t      value
);

  gpd_word_t value_q;
  gpd_word_t value_d;

  // Only the 16 implemented bits exist, so upper written bits cannot reach anything
  always_comb
  begin
    unique case (op)
      GPD_OP_LOAD: value_d = wrData;
      GPD_OP_CLR:  value_d = value_q & ~wrData;
      GPD_OP_SET:  value_d = value_q | wrData;
      GPD_OP_INV:  value_d = value_q ^ wrData;
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      value_q <= RESET_VALUE;
    else if (wrEn)
      value_q <= value_d;
  end

  assign value = value_q;

endmodule

// ===== rtl/gpd_pin_sync.sv
`timescale 1ns/10ps
`include "gpd_defs.svh"

module gpd_pin_sync
  import gpd_pkg::*;
(
  // Clock and reset
  input  wire logic      mclk,
  input  wire logic      rst,
  // Pins and sample
  input  wire gpd_word_t pinIn,
  output gpd_word_t      pinLevel
);

  // Pins are synchronous to mclk; one register keeps read timing fixed
  gpd_word_t level_q;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      level_q <= 16'h0000;
    else
      level_q <= pinIn;
  end

  assign pinLevel = level_q;

endmodule

// ===== rtl/gpd_port.sv
// Operation
// [R01] Each direction bit set to one makes its pin an input with the driver off, zero makes it an output.
// [R02] After reset all sixteen direction bits are one so every pin starts as an input.
// [R03] Software writes zero to bits 31 to 16 and ignores them on read.
// [R04] A direction-clear write clears each direction bit written as one.
// [R05] A direction-set write sets each direction bit written as one.
// [R06] A direction-invert write toggles each direction bit written as one.
// [R07] Zero bits in any clear, set or invert write leave the target bit alone.
// [R08] Companion writes never change unimplemented or read-only bits.
// [R09] Reads of companion registers return an undefined value that nobody relies on.
// [R10] Reading the pin-level register returns the sampled pin levels, not the latch.
// [R11] Writing the pin-level register loads the output latch that drives output pins.
// [R12] A pin-level clear write clears each latch bit written as one.
// [R13] A pin-level set write sets each latch bit written as one.
// [R14] A pin-level invert write toggles each latch bit written as one.
// [R15] Reading the output latch register returns the stored latch value.
// [R16] A pin with direction zero is driven from its latch bit, otherwise its driver is off.
`timescale 1ns/10ps
`include "gpd_defs.svh"

module gpd_port
  import gpd_pkg::*;
(
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rst,
  // Register port
  input  wire logic [`GPD_ADDR_W-1:0]   regAddr,
  input  wire logic [31:0]              regWrData,
  input  wire logic                     regWr,
  input  wire logic                     regRd,
  output logic      [31:0]              regRdData,
  // Pins
  input  wire logic [`GPD_PINS-1:0]     pinIn,
  output logic      [`GPD_PINS-1:0]     pinOut,
  output logic      [`GPD_PINS-1:0]     pinOe
);

  gpd_word_t   dirValue;
  gpd_word_t   latValue;
  gpd_word_t   pinLevel;
  logic [31:0] rdData_q;
  logic [31:0] rdData_d;
  gpd_word_t   pinOut_q;
  gpd_word_t   pinOe_q;

  // Map low two index bits to the companion operation
  function automatic gpd_op_t opOf(input logic [`GPD_ADDR_W-1:0] idx);
    opOf = gpd_op_t'(idx[1:0]);
  endfunction

  wire logic    dirHit = regAddr[`GPD_ADDR_W-1:2] == `GPD_DIR_IDX >> 2;
  wire logic    lvlHit = regAddr[`GPD_ADDR_W-1:2] == `GPD_LVL_IDX >> 2;
  wire logic    latHit = regAddr[`GPD_ADDR_W-1:2] == `GPD_LAT_IDX >> 2;
  wire gpd_op_t wrOp   = opOf(regAddr);
  // Upper written bits are dropped here, so they touch nothing
  // [R08] drop unimplemented bits
  wire gpd_word_t wrBits = regWrData[15:0];
  wire logic    dirWr  = regWr & dirHit;
  // Level and latch addresses share one latch
  wire logic    latWr  = regWr & (lvlHit | latHit);

  // [R02] direction resets high
  // [R04] [R05] [R06] [R07] direction companions
  gpd_modify_reg #(
    .RESET_VALUE (`GPD_DIR_RESET)
  ) dirReg (
    .mclk   (mclk),
    .rst    (rst),
    .wrEn   (dirWr),
    .op     (wrOp),
    .wrData (wrBits),
    .value  (dirValue)
  );

  // [R11] [R12] [R13] [R14] latch updates
  gpd_modify_reg #(
    .RESET_VALUE (`GPD_LAT_RESET)
  ) latReg (
    .mclk   (mclk),
    .rst    (rst),
    .wrEn   (latWr),
    .op     (wrOp),
    .wrData (wrBits),
    .value  (latValue)
  );

  gpd_pin_sync pinSync (
    .mclk     (mclk),
    .rst      (rst),
    .pinIn    (pinIn),
    .pinLevel (pinLevel)
  );

  // Read mux; reserved and unmapped read as zero
  always_comb
  begin
    rdData_d = 32'h00000000;
    if (regRd)
    begin
      // [R09] companions read fixed value
      if (wrOp != GPD_OP_LOAD)
        rdData_d = `GPD_UNDEF_READ;
      else if (dirHit)
        rdData_d = {16'h0000, dirValue};
      // [R10] pins, not latch
      else if (lvlHit)
        rdData_d = {16'h0000, pinLevel};
      // [R15] latch value
      else if (latHit)
        rdData_d = {16'h0000, latValue};
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      rdData_q <= 32'h00000000;
    else
      rdData_q <= rdData_d;
  end

  // [R01] [R16] pin drivers from latch
  // Registered outputs add one cycle after the register change
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pinOut_q <= 16'h0000;
      pinOe_q  <= 16'h0000;
    end
    else
    begin
      pinOut_q <= latValue;
      pinOe_q  <= ~dirValue;
    end
  end

  assign regRdData = rdData_q;
  assign pinOut    = pinOut_q;
  assign pinOe     = pinOe_q;

endmodule

// ===== bench/gpd_port_assertions.sv
`timescale 1ns/10ps
`include "gpd_defs.svh"
module gpd_port_assertions
  import gpd_pkg::*;
(
  // Watched ports
  input wire logic                   mclk,
  input wire logic                   rst,
  input wire logic [`GPD_ADDR_W-1:0] regAddr,
  input wire logic [31:0]            regWrData,
  input wire logic                   regWr,
  input wire logic                   regRd,
  input wire logic [31:0]            regRdData,
  input wire logic [`GPD_PINS-1:0]   pinIn,
  input wire logic [`GPD_PINS-1:0]   pinOut,
  input wire logic [`GPD_PINS-1:0]   pinOe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Pins lag a write by two edges, so a second write in between is excluded
  wire [15:0] m  = regWrData[15:0];
  wire        dW = regWr && regAddr < 4;
  wire        lW = regWr && regAddr > 3 && regAddr < 12;
  a_dir_clear: assert property (
    regWr && regAddr == 1 ##1 !dW |=> (pinOe & $past(m, 2)) == $past(m, 2))
    else $error("dir clear");
  a_dir_set: assert property (
    regWr && regAddr == 2 ##1 !dW |=> (pinOe & $past(m, 2)) == 0)
    else $error("dir set");
  a_dir_invert: assert property (
    regWr && regAddr == 3 ##1 !dW |=> (pinOe ^ $past(pinOe)) == $past(m, 2))
    else $error("dir invert");
  a_latch_load: assert property (
    regWr && regAddr[1:0] == 0 && lW ##1 !lW |=> pinOut == $past(m, 2))
    else $error("latch load");
  a_latch_clear: assert property (
    regWr && regAddr[1:0] == 1 && lW ##1 !lW |=> (pinOut & $past(m, 2)) == 0)
    else $error("latch clear");
  a_latch_set: assert property (
    regWr && regAddr[1:0] == 2 && lW ##1 !lW |=> (pinOut & $past(m, 2)) == $past(m, 2))
    else $error("latch set");
  a_latch_invert: assert property (
    regWr && regAddr[1:0] == 3 && lW ##1 !lW |=> (pinOut ^ $past(pinOut)) == $past(m, 2))
    else $error("latch invert");
  a_level_read: assert property (
    regRd && regAddr == 4 && $stable(pinIn) |=> regRdData[15:0] == $past(pinIn))
    else $error("level read");
  cover property (regRd && regAddr == 4);
  cover property (regWr && regAddr == 3);
  cover property (regWr && regAddr == 11);
endmodule

bind gpd_port gpd_port_assertions gpd_port_assertions_i (.mclk, .rst, .regAddr, .regWrData, .regWr, .regRd,
  .regRdData, .pinIn, .pinOut, .pinOe);

// ===== bench/test_gpd_port.sv
`timescale 1ns/10ps
module test_gpd_port
  import gpd_pkg::*;
;
  logic        mclk = 0, rst = 1, regWr = 0, regRd = 0, rdQ = 0;
  logic [5:0]  regAddr = 0;
  logic [31:0] regWrData = 0, regRdData;
  gpd_word_t   pinIn = 0, pinOut, pinOe, dirM = 16'hffff, latM = 0, q[$];
  int          n_fail = 0, compares = 0, i;
  always #2.5 mclk = ~mclk;
  gpd_port gpd_port_i (.mclk, .rst, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .pinIn, .pinOut, .pinOe);
  task check(input gpd_word_t s, e);
    compares++;
    if (s !== e)
    begin
      n_fail++;
      $display("BAD %0t %h %h", $time, s, e);
    end
  endtask
  task finish_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  function gpd_word_t f(gpd_word_t v, logic [1:0] op, gpd_word_t d);
    case (op)
      2'h0: f = d;
      2'h1: f = v & ~d;
      2'h2: f = v | d;
      default: f = v ^ d;
    endcase
  endfunction
  task wr(input logic [5:0] a, input gpd_word_t d);
    @(posedge mclk);
    regWr <= 1'h1;
    regAddr <= a;
    regWrData <= {16'h0, d};
    @(posedge mclk);
    regWr <= 1'h0;
    if (a < 4) dirM = f(dirM, a[1:0], d);
    else latM = f(latM, a[1:0], d);
  endtask
  task rd(input logic [5:0] a, input gpd_word_t e);
    @(posedge mclk);
    regRd <= 1'h1;
    regAddr <= a;
    q.push_back(e);
    @(posedge mclk);
    regRd <= 1'h0;
  endtask
  task pins;
    repeat (2) @(posedge mclk);
    check(pinOe, ~dirM);
    check(pinOut, latM);
  endtask
  // Reads show up one cycle after the strobe
  always @(posedge mclk)
  begin
    if (rdQ)
      check(regRdData[15:0], q.pop_front());
    rdQ <= regRd;
  end
  initial
  begin
    void'($urandom(32'h0f7b));
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    rd(6'h0, 16'hffff);
    pins;
    for (i = 0; i < 36; i++)
    begin
      wr(6'(i % 12), 16'($urandom));
      pins;
      rd(6'h0, dirM);
      rd(6'h8, latM);
      pinIn <= 16'($urandom);
      repeat (3) @(posedge mclk);
      rd(6'h4, pinIn);
    end
    rd(6'h20, 16'h0);
    finish_test;
  end
  initial
  begin
    #20000;
    n_fail++;
    finish_test;
  end
endmodule
